// File: inc/pic_pkg.sv
// Constants for the port ingress classification control block.
`default_nettype none
package pic_pkg;
    // ------------------------------------------------------------
    // Register indices and byte addresses
    // ------------------------------------------------------------
    localparam logic [15:0] PIC_IDX_PRIO_SRC = 16'h0801;
    localparam logic [15:0] PIC_IDX_INGRESS = 16'h0802;
    localparam logic [15:0] PIC_IDX_AUTH = 16'h0803;
    localparam logic [15:0] PIC_IDX_PTR = 16'h0804;
    localparam logic [15:0] PIC_IDX_MAP = 16'h0808;
    localparam logic [15:0] PIC_ADDR_PRIO_SRC = {PIC_IDX_PRIO_SRC[13:0], 2'b00};
    localparam logic [15:0] PIC_ADDR_INGRESS = {PIC_IDX_INGRESS[13:0], 2'b00};
    localparam logic [15:0] PIC_ADDR_AUTH = {PIC_IDX_AUTH[13:0], 2'b00};
    localparam logic [15:0] PIC_ADDR_PTR = {PIC_IDX_PTR[13:0], 2'b00};
    localparam logic [15:0] PIC_ADDR_MAP = {PIC_IDX_MAP[13:0], 2'b00};
    // ------------------------------------------------------------
    // Writable bit masks and reset values
    // ------------------------------------------------------------
    localparam logic [31:0] PIC_PRIO_SRC_WMASK = 32'h0000_00DF;
    localparam logic [31:0] PIC_INGRESS_WMASK = 32'h0000_009F;
    localparam logic [31:0] PIC_AUTH_WMASK = 32'h0000_0003;
    localparam logic [31:0] PIC_PTR_WMASK = 32'h0007_0003;
    localparam logic [31:0] PIC_MAP_WMASK = 32'h3333_3333;
    localparam logic [7:0] PIC_PRIO_SRC_RST = 8'h00;
    localparam logic [7:0] PIC_INGRESS_RST = 8'h00;
    localparam logic [1:0] PIC_AUTH_RST = 2'h0;
    localparam logic [2:0] PIC_PORT_IDX_RST = 3'h0;
    localparam logic [1:0] PIC_QUEUE_PTR_RST = 2'h0;
    localparam logic [31:0] PIC_MAP_RST = 32'h3322_1100;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int PIC_ING_CAP_BIT = 7;
    localparam int PIC_ING_DROP_UNTAG_BIT = 4;
    localparam int PIC_ING_DROP_TAG_BIT = 3;
    localparam int PIC_AUTH_ACL_EN_BIT = 2;
    localparam int PIC_PTR_PORT_LSB = 16;
    localparam int PIC_SRC_EN_LSB = 1;
    // ------------------------------------------------------------
    // Authentication modes and bus responses
    // ------------------------------------------------------------
    localparam logic [1:0] PIC_AUTH_RESERVED = 2'h0;
    localparam logic [1:0] PIC_AUTH_BLOCK = 2'h1;
    localparam logic [1:0] PIC_AUTH_PASS = 2'h2;
    localparam logic [1:0] PIC_AUTH_TRAP = 2'h3;
    localparam logic [1:0] PIC_RESP_OKAY = 2'h0;
    localparam logic [1:0] PIC_RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// File: inc/pic_cfg_if.sv
// Configuration carried from the register bank to the frame classifier.
`default_nettype none
interface pic_cfg_if;
    logic cap_en;
    logic drop_untag;
    logic drop_tag;
    logic [2:0] dflt_prio;
    logic [1:0] auth_mode;
    logic [2:0] src_en;
    logic [31:0] map;
    modport regs (output cap_en, output drop_untag, output drop_tag, output dflt_prio, output auth_mode,
                  output src_en, output map);
    modport cls (input cap_en, input drop_untag, input drop_tag, input dflt_prio, input auth_mode,
                 input src_en, input map);
endinterface
`default_nettype wire

// File: hw/pic_classify.sv
// Per-frame drop, priority, queue and authentication decision.
`default_nettype none
module pic_classify (
    input wire logic aclk,
    input wire logic aresetn,
    pic_cfg_if.cls cfg,
    input wire logic frm_valid,
    input wire logic frm_tagged,
    input wire logic [2:0] frm_tag_prio,
    input wire logic [2:0] frm_cls_hit,
    input wire logic [2:0] frm_cls_prio,
    input wire logic frm_acl_match,
    input wire logic frm_acl_drop,
    input wire logic [2:0] default_tag_prio,
    input wire logic access_list_en,
    output logic res_valid,
    output logic res_drop,
    output logic [2:0] res_prio,
    output logic [2:0] res_tag_prio,
    output logic [1:0] res_queue,
    output logic res_to_host,
    output logic res_auth_req
);
    // ------------------------------------------------------------
    // Decision logic
    // ------------------------------------------------------------
    logic use_cls;
    logic [2:0] prio;
    logic [2:0] tag_prio;
    logic acl_drop;
    logic drop;
    logic miss_blocks;

    assign use_cls = |(frm_cls_hit & cfg.src_en);
    assign prio = use_cls ? frm_cls_prio : cfg.dflt_prio;
    assign tag_prio = (cfg.cap_en && frm_tagged && (frm_tag_prio > default_tag_prio)) ?
                      default_tag_prio : frm_tag_prio;
    assign miss_blocks = (cfg.auth_mode == pic_pkg::PIC_AUTH_BLOCK) ||
                         (cfg.auth_mode == pic_pkg::PIC_AUTH_TRAP);
    assign acl_drop = access_list_en && (frm_acl_match ? frm_acl_drop : miss_blocks);
    assign drop = (cfg.drop_untag && !frm_tagged) || (cfg.drop_tag && frm_tagged) || acl_drop;

    // ------------------------------------------------------------
    // Registered result
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            res_valid <= 1'b0;
        end else begin
            res_valid <= frm_valid;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            res_drop <= 1'b0;
            res_prio <= 3'h0;
            res_tag_prio <= 3'h0;
            res_queue <= 2'h0;
            res_to_host <= 1'b0;
            res_auth_req <= 1'b0;
        end else if (frm_valid) begin
            res_drop <= drop;
            res_prio <= prio;
            res_tag_prio <= tag_prio;
            res_queue <= cfg.map[{prio, 2'b00} +: 2];
            res_to_host <= (cfg.auth_mode == pic_pkg::PIC_AUTH_TRAP) && !drop;
            res_auth_req <= miss_blocks;
        end
    end
endmodule
`default_nettype wire

// File: hw/pic_port_ingress.sv
// Port ingress control register bank with AXI4-Lite access and frame classifier.
// What this block does
// - Cap tag priority to default when enabled.
// - Discard untagged frames when drop-untagged set.
// - Discard tagged frames when drop-tagged set.
// - Use fallback priority when no classifier hits.
// - Block mode: enforce, block access-list misses.
// - Pass mode: forward access-list misses; matched drop entries still drop.
// - Trap mode: enforce, send frames that are not dropped to host.
// - Read-only access-list enable indicator at bit two.
// - Writable three-bit port index, resets zero.
// - Writable two-bit queue pointer, resets zero.
// - Two-bit field per priority, at four-bit spacing, selects queue.
// - Reset map pairs priorities onto queues.
// - Source enables gate the classifier hits.
//
// The AXI4-Lite interface to the registers was left to the implementer.
`default_nettype none
module pic_port_ingress (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [15:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [15:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic frm_valid,
    input wire logic frm_tagged,
    input wire logic [2:0] frm_tag_prio,
    input wire logic [2:0] frm_cls_hit,
    input wire logic [2:0] frm_cls_prio,
    input wire logic frm_acl_match,
    input wire logic frm_acl_drop,
    input wire logic [2:0] default_tag_prio,
    input wire logic access_list_en,
    output logic res_valid,
    output logic res_drop,
    output logic [2:0] res_prio,
    output logic [2:0] res_tag_prio,
    output logic [1:0] res_queue,
    output logic res_to_host,
    output logic res_auth_req,
    output logic [2:0] port_index,
    output logic [1:0] queue_ptr
);
    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [7:0] prio_src_q;
    logic [7:0] ing_q;
    logic [1:0] auth_q;
    logic [2:0] port_idx_q;
    logic [1:0] queue_ptr_q;
    logic [31:0] map_q;
    logic aw_got_q;
    logic w_got_q;
    logic [15:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [1:0] rresp_q;
    logic [31:0] rdata_q;
    logic wr_fire;
    logic wr_hit;
    logic [31:0] rd_word;
    logic rd_hit;
    logic [31:0] ptr_word;
    logic [31:0] prio_src_wr;
    logic [31:0] ing_wr;
    logic [31:0] auth_wr;
    logic [31:0] ptr_wr;
    logic [31:0] map_wr;

    function automatic logic [31:0] pic_merge(input logic [31:0] cur, input logic [31:0] nxt,
                                              input logic [3:0] strb, input logic [31:0] wmask);
        logic [31:0] lanes;
        lanes = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        return ((cur & ~lanes) | (nxt & lanes)) & wmask;
    endfunction

    // ------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------
    assign awready = !aw_got_q && !bvalid_q;
    assign wready = !w_got_q && !bvalid_q;
    assign wr_fire = aw_got_q && w_got_q && !bvalid_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign wr_hit = (awaddr_q == pic_pkg::PIC_ADDR_PRIO_SRC) || (awaddr_q == pic_pkg::PIC_ADDR_INGRESS) ||
                    (awaddr_q == pic_pkg::PIC_ADDR_AUTH) || (awaddr_q == pic_pkg::PIC_ADDR_PTR) ||
                    (awaddr_q == pic_pkg::PIC_ADDR_MAP);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            awaddr_q <= 16'h0000;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= pic_pkg::PIC_RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                aw_got_q <= 1'b1;
                awaddr_q <= awaddr;
            end
            if (wvalid && wready) begin
                w_got_q <= 1'b1;
                wdata_q <= wdata;
                wstrb_q <= wstrb;
            end
            if (wr_fire) begin
                aw_got_q <= 1'b0;
                w_got_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= wr_hit ? pic_pkg::PIC_RESP_OKAY : pic_pkg::PIC_RESP_SLVERR;
            end else if (bvalid_q && bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Register updates
    // ------------------------------------------------------------
    assign ptr_word = {13'h0000, port_idx_q, 14'h0000, queue_ptr_q};
    assign prio_src_wr = pic_merge({24'h000000, prio_src_q}, wdata_q, wstrb_q, pic_pkg::PIC_PRIO_SRC_WMASK);
    assign ing_wr = pic_merge({24'h000000, ing_q}, wdata_q, wstrb_q, pic_pkg::PIC_INGRESS_WMASK);
    assign auth_wr = pic_merge({30'h00000000, auth_q}, wdata_q, wstrb_q, pic_pkg::PIC_AUTH_WMASK);
    assign ptr_wr = pic_merge(ptr_word, wdata_q, wstrb_q, pic_pkg::PIC_PTR_WMASK);
    assign map_wr = pic_merge(map_q, wdata_q, wstrb_q, pic_pkg::PIC_MAP_WMASK);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prio_src_q <= pic_pkg::PIC_PRIO_SRC_RST;
        end else if (wr_fire && awaddr_q == pic_pkg::PIC_ADDR_PRIO_SRC) begin
            prio_src_q <= prio_src_wr[7:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ing_q <= pic_pkg::PIC_INGRESS_RST;
        end else if (wr_fire && awaddr_q == pic_pkg::PIC_ADDR_INGRESS) begin
            ing_q <= ing_wr[7:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            auth_q <= pic_pkg::PIC_AUTH_RST;
        end else if (wr_fire && awaddr_q == pic_pkg::PIC_ADDR_AUTH) begin
            auth_q <= auth_wr[1:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            port_idx_q <= pic_pkg::PIC_PORT_IDX_RST;
            queue_ptr_q <= pic_pkg::PIC_QUEUE_PTR_RST;
        end else if (wr_fire && awaddr_q == pic_pkg::PIC_ADDR_PTR) begin
            port_idx_q <= ptr_wr[pic_pkg::PIC_PTR_PORT_LSB +: 3];
            queue_ptr_q <= ptr_wr[1:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            map_q <= pic_pkg::PIC_MAP_RST;
        end else if (wr_fire && awaddr_q == pic_pkg::PIC_ADDR_MAP) begin
            map_q <= map_wr;
        end
    end

    assign port_index = port_idx_q;
    assign queue_ptr = queue_ptr_q;

    // ------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------
    assign arready = !rvalid_q;
    assign rvalid = rvalid_q;
    assign rresp = rresp_q;
    assign rdata = rdata_q;

    always_comb begin
        rd_word = 32'h0000_0000;
        rd_hit = 1'b1;
        case (araddr)
            pic_pkg::PIC_ADDR_PRIO_SRC: rd_word = {24'h000000, prio_src_q};
            pic_pkg::PIC_ADDR_INGRESS: rd_word = {24'h000000, ing_q};
            pic_pkg::PIC_ADDR_AUTH: rd_word = {29'h00000000, access_list_en, auth_q};
            pic_pkg::PIC_ADDR_PTR: rd_word = ptr_word;
            pic_pkg::PIC_ADDR_MAP: rd_word = map_q;
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rresp_q <= pic_pkg::PIC_RESP_OKAY;
            rdata_q <= 32'h0000_0000;
        end else if (arvalid && arready) begin
            rvalid_q <= 1'b1;
            rresp_q <= rd_hit ? pic_pkg::PIC_RESP_OKAY : pic_pkg::PIC_RESP_SLVERR;
            rdata_q <= rd_word;
        end else if (rvalid_q && rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Frame classifier
    // ------------------------------------------------------------
    pic_cfg_if cfg_if ();

    assign cfg_if.cap_en = ing_q[pic_pkg::PIC_ING_CAP_BIT];
    assign cfg_if.drop_untag = ing_q[pic_pkg::PIC_ING_DROP_UNTAG_BIT];
    assign cfg_if.drop_tag = ing_q[pic_pkg::PIC_ING_DROP_TAG_BIT];
    assign cfg_if.dflt_prio = ing_q[2:0];
    assign cfg_if.auth_mode = auth_q;
    assign cfg_if.src_en = prio_src_q[pic_pkg::PIC_SRC_EN_LSB +: 3];
    assign cfg_if.map = map_q;

    pic_classify u_classify (
        .aclk(aclk),
        .aresetn(aresetn),
        .cfg(cfg_if.cls),
        .frm_valid(frm_valid),
        .frm_tagged(frm_tagged),
        .frm_tag_prio(frm_tag_prio),
        .frm_cls_hit(frm_cls_hit),
        .frm_cls_prio(frm_cls_prio),
        .frm_acl_match(frm_acl_match),
        .frm_acl_drop(frm_acl_drop),
        .default_tag_prio(default_tag_prio),
        .access_list_en(access_list_en),
        .res_valid(res_valid),
        .res_drop(res_drop),
        .res_prio(res_prio),
        .res_tag_prio(res_tag_prio),
        .res_queue(res_queue),
        .res_to_host(res_to_host),
        .res_auth_req(res_auth_req)
    );

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    logic [31:0] map_d1_q;

    always_ff @(posedge aclk) begin
        map_d1_q <= map_q;
    end

    prio_cap_a: assert property (@(posedge aclk) disable iff (!aresetn)
        frm_valid && frm_tagged && ing_q[7] && (frm_tag_prio > default_tag_prio)
        |=> res_valid && (res_tag_prio == $past(default_tag_prio)))
        else $error("Tag priority was not capped.");

    prio_keep_a: assert property (@(posedge aclk) disable iff (!aresetn)
        frm_valid && !ing_q[7] |=> res_tag_prio == $past(frm_tag_prio))
        else $error("Tag priority changed with cap off.");

    untag_drop_a: assert property (@(posedge aclk) disable iff (!aresetn)
        frm_valid && !frm_tagged && ing_q[4] |=> res_valid && res_drop)
        else $error("Untagged frame was not dropped.");

    tag_drop_a: assert property (@(posedge aclk) disable iff (!aresetn)
        frm_valid && frm_tagged && ing_q[3] |=> res_valid && res_drop)
        else $error("Tagged frame was not dropped.");

    fallback_prio_a: assert property (@(posedge aclk) disable iff (!aresetn)
        frm_valid && ((frm_cls_hit & prio_src_q[3:1]) == 3'h0) |=> res_prio == $past(ing_q[2:0]))
        else $error("Fallback priority not applied.");

    block_miss_a: assert property (@(posedge aclk) disable iff (!aresetn)
        frm_valid && access_list_en && !frm_acl_match && auth_q[0] |=> res_drop && res_auth_req)
        else $error("Access-list miss not blocked.");

    pass_miss_a: assert property (@(posedge aclk) disable iff (!aresetn)
        frm_valid && auth_q == pic_pkg::PIC_AUTH_PASS && !frm_acl_match && !ing_q[4] && !ing_q[3]
        |=> !res_drop && !res_auth_req && !res_to_host)
        else $error("Pass mode dropped a miss.");

    trap_host_a: assert property (@(posedge aclk) disable iff (!aresetn)
        frm_valid && auth_q == pic_pkg::PIC_AUTH_TRAP && !access_list_en && !ing_q[4] && !ing_q[3]
        |=> res_to_host && res_auth_req)
        else $error("Trap mode did not send to host.");

    acl_bit_a: assert property (@(posedge aclk) disable iff (!aresetn)
        arvalid && arready && araddr == pic_pkg::PIC_ADDR_AUTH
        |=> rvalid && rdata[2] == $past(access_list_en) && rdata[31:3] == 29'h00000000)
        else $error("Access-list enable bit read wrong.");

    ptr_reset_a: assert property (@(posedge aclk)
        !aresetn |=> port_index == 3'h0 && queue_ptr == 2'h0)
        else $error("Pointer not zero after reset.");

    queue_map_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $past(frm_valid) && res_valid |-> res_queue == map_d1_q[{res_prio, 2'b00} +: 2])
        else $error("Queue does not follow the map.");

    map_reset_a: assert property (@(posedge aclk)
        !aresetn |=> map_q == 32'h3322_1100)
        else $error("Map reset value wrong.");

    rsvd_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
        arvalid && arready && araddr == pic_pkg::PIC_ADDR_MAP
        |=> rvalid && (rdata & ~pic_pkg::PIC_MAP_WMASK) == 32'h0000_0000)
        else $error("Reserved bits hold nonzero.");

    write_resp_a: assert property (@(posedge aclk) disable iff (!aresetn)
        aw_got_q && w_got_q && !bvalid_q |=> bvalid ##0 $stable(wdata_q))
        else $error("Write response missing.");

    trap_cover_c: cover property (@(posedge aclk) disable iff (!aresetn)
        res_valid && res_to_host);
    untag_cover_c: cover property (@(posedge aclk) disable iff (!aresetn)
        frm_valid && !frm_tagged && ing_q[4] ##1 res_drop);
    cap_cover_c: cover property (@(posedge aclk) disable iff (!aresetn)
        frm_valid && frm_tagged && ing_q[7] && (frm_tag_prio > default_tag_prio));
    map_wr_cover_c: cover property (@(posedge aclk) disable iff (!aresetn)
        wr_fire && awaddr_q == pic_pkg::PIC_ADDR_MAP ##1 bvalid);
endmodule
`default_nettype wire

// File: testbench/pic_port_ingress_tb.sv
// Self-checking testbench for the port ingress classification control block.
`default_nettype none
`define CHK(nm, e, s) begin compares++; if ((s) !== (e)) begin failures++; \
    $display("wrong value %s expected %0h seen %0h", nm, e, s); end end
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    // ------------------------------------------------------------
    // Signals, clock and design instance
    // ------------------------------------------------------------
    typedef struct packed {logic [7:0] ing; logic [7:0] src; logic [1:0] md; logic ale; logic tg; logic [2:0] tp;
        logic [2:0] hit; logic [2:0] cp; logic m; logic ad; logic [2:0] dtp; logic dr; logic [2:0] pr;
        logic [2:0] tpo; logic th; logic ar;} pic_row_t;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [15:0] awaddr = 16'h0000, araddr = 16'h0000;
    logic [31:0] wdata = 32'h0000_0000, rdata;
    logic [3:0] wstrb = 4'hF;
    logic awready, wready, bvalid, arready, rvalid, res_valid, res_drop, res_to_host, res_auth_req;
    logic [1:0] bresp, rresp, res_queue, queue_ptr, rs;
    logic frm_valid = 0, frm_tagged = 0, frm_acl_match = 0, frm_acl_drop = 0, access_list_en = 0;
    logic [2:0] frm_tag_prio = 3'h0, frm_cls_hit = 3'h0, frm_cls_prio = 3'h0, default_tag_prio = 3'h0;
    logic [2:0] res_prio, res_tag_prio, port_index;
    logic [31:0] rd;
    int failures = 0, compares = 0, cycles = 0;
    pic_row_t r;
    pic_row_t rows [15] = '{
        '{8'h85, 8'h00, 2, 0, 1, 6, 0, 0, 0, 0, 4, 0, 5, 4, 0, 0}, '{8'h80, 8'h00, 2, 0, 0, 7, 0, 0, 0, 0, 2, 0, 0, 7, 0, 0},
        '{8'h07, 8'h00, 2, 0, 1, 7, 0, 0, 0, 0, 1, 0, 7, 7, 0, 0}, '{8'h10, 8'h00, 2, 0, 0, 1, 0, 0, 0, 0, 0, 1, 0, 1, 0, 0},
        '{8'h10, 8'h00, 2, 0, 1, 1, 0, 0, 0, 0, 0, 0, 0, 1, 0, 0}, '{8'h08, 8'h00, 2, 0, 1, 2, 0, 0, 0, 0, 0, 1, 0, 2, 0, 0},
        '{8'h02, 8'h0E, 2, 0, 1, 0, 4, 6, 0, 0, 0, 0, 6, 0, 0, 0}, '{8'h02, 8'h02, 2, 0, 1, 0, 4, 6, 0, 0, 0, 0, 2, 0, 0, 0},
        '{8'h00, 8'h00, 1, 1, 1, 0, 0, 0, 0, 0, 0, 1, 0, 0, 0, 1}, '{8'h00, 8'h00, 1, 1, 1, 0, 0, 0, 1, 0, 0, 0, 0, 0, 0, 1},
        '{8'h00, 8'h00, 2, 1, 1, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0}, '{8'h00, 8'h00, 2, 1, 1, 0, 0, 0, 1, 1, 0, 1, 0, 0, 0, 0},
        '{8'h00, 8'h00, 0, 1, 1, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0},
        '{8'h00, 8'h00, 3, 1, 1, 0, 0, 0, 0, 0, 0, 1, 0, 0, 0, 1}, '{8'h00, 8'h00, 3, 0, 1, 0, 0, 0, 0, 0, 0, 0, 0, 0, 1, 1}};
    always #2.5 aclk = ~aclk;
    pic_port_ingress DUT (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .frm_valid(frm_valid), .frm_tagged(frm_tagged),
        .frm_tag_prio(frm_tag_prio), .frm_cls_hit(frm_cls_hit), .frm_cls_prio(frm_cls_prio),
        .frm_acl_match(frm_acl_match), .frm_acl_drop(frm_acl_drop), .default_tag_prio(default_tag_prio),
        .access_list_en(access_list_en), .res_valid(res_valid), .res_drop(res_drop), .res_prio(res_prio),
        .res_tag_prio(res_tag_prio), .res_queue(res_queue), .res_to_host(res_to_host),
        .res_auth_req(res_auth_req), .port_index(port_index), .queue_ptr(queue_ptr));
    // ------------------------------------------------------------
    // Bus and frame tasks
    // ------------------------------------------------------------
    task automatic wr(input logic [15:0] a, input logic [31:0] d, output logic [1:0] resp);
        logic ad, wd, ta, tw;
        ad = 0;
        wd = 0;
        @(posedge aclk);
        awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
        while (!(ad && wd)) begin
            @(negedge aclk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            @(posedge aclk);
            if (ta) begin awvalid <= 0; ad = 1; end
            if (tw) begin wvalid <= 0; wd = 1; end
        end
        do @(negedge aclk); while (bvalid !== 1'b1);
        resp = bresp;
        @(posedge aclk);
        bready <= 0;
    endtask
    task automatic rdr(input logic [15:0] a, output logic [31:0] d, output logic [1:0] resp);
        @(posedge aclk);
        araddr <= a; arvalid <= 1; rready <= 1;
        do @(negedge aclk); while (arready !== 1'b1);
        @(posedge aclk);
        arvalid <= 0;
        do @(negedge aclk); while (rvalid !== 1'b1);
        d = rdata;
        resp = rresp;
        @(posedge aclk);
        rready <= 0;
    endtask
    task automatic frame(input pic_row_t x);
        @(posedge aclk);
        frm_valid <= 1; frm_tagged <= x.tg; frm_tag_prio <= x.tp; frm_cls_hit <= x.hit; frm_cls_prio <= x.cp;
        frm_acl_match <= x.m; frm_acl_drop <= x.ad; default_tag_prio <= x.dtp; access_list_en <= x.ale;
        @(posedge aclk);
        frm_valid <= 0;
        @(negedge aclk);
        `CHK("res_valid", 1'b1, res_valid)
    endtask
    task automatic tally_and_finish;
        $display("failures %0d compares %0d", failures, compares);
        if (failures == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            tally_and_finish();
        end
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        foreach (rows[i]) begin
            r = rows[i];
            wr(pic_pkg::PIC_ADDR_INGRESS, {24'h0, r.ing}, rs);
            wr(pic_pkg::PIC_ADDR_PRIO_SRC, {24'h0, r.src}, rs);
            wr(pic_pkg::PIC_ADDR_AUTH, {30'h0, r.md}, rs);
            `CHK("bresp", pic_pkg::PIC_RESP_OKAY, rs)
            frame(r);
            `CHK("drop", r.dr, res_drop)
            `CHK("prio", r.pr, res_prio)
            `CHK("tag_prio", r.tpo, res_tag_prio)
            `CHK("queue", r.pr[2:1], res_queue)
            `CHK("to_host", r.th, res_to_host)
            `CHK("auth_req", r.ar, res_auth_req)
            @(negedge aclk);
            `CHK("res_valid low", 1'b0, res_valid)
        end
        @(posedge aclk);
        aresetn <= 0;
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        rdr(pic_pkg::PIC_ADDR_MAP, rd, rs);
        `CHK("map reset", 32'h3322_1100, rd)
        `CHK("rresp", pic_pkg::PIC_RESP_OKAY, rs)
        rdr(pic_pkg::PIC_ADDR_AUTH, rd, rs);
        `CHK("auth reset", 32'h0000_0000, rd)
        rdr(pic_pkg::PIC_ADDR_PTR, rd, rs);
        `CHK("ptr reset", 32'h0000_0000, rd)
        wr(pic_pkg::PIC_ADDR_PTR, 32'hFFFF_FFFF, rs);
        rdr(pic_pkg::PIC_ADDR_PTR, rd, rs);
        `CHK("ptr read", 32'h0007_0003, rd)
        `CHK("port_index", 3'h7, port_index)
        `CHK("queue_ptr", 2'h3, queue_ptr)
        wr(pic_pkg::PIC_ADDR_INGRESS, 32'hFFFF_FFFF, rs);
        rdr(pic_pkg::PIC_ADDR_INGRESS, rd, rs);
        `CHK("ingress read", 32'h0000_009F, rd)
        wr(pic_pkg::PIC_ADDR_AUTH, 32'hFFFF_FFFF, rs);
        @(posedge aclk);
        access_list_en <= 1'b1;
        rdr(pic_pkg::PIC_ADDR_AUTH, rd, rs);
        `CHK("auth read", 32'h0000_0007, rd)
        wr(pic_pkg::PIC_ADDR_MAP, 32'hFFFF_FFFF, rs);
        rdr(pic_pkg::PIC_ADDR_MAP, rd, rs);
        `CHK("map read", 32'h3333_3333, rd)
        wr(pic_pkg::PIC_ADDR_MAP, 32'h0123_0123, rs);
        wr(pic_pkg::PIC_ADDR_INGRESS, 32'h0000_0005, rs);
        wr(pic_pkg::PIC_ADDR_AUTH, 32'h0000_0002, rs);
        r = '{8'h05, 8'h00, 2, 0, 0, 0, 0, 0, 0, 0, 0, 0, 5, 0, 0, 0};
        frame(r);
        `CHK("mapped queue", 2'h2, res_queue)
        wr(16'h0100, 32'h0000_00FF, rs);
        `CHK("unmapped bresp", pic_pkg::PIC_RESP_SLVERR, rs)
        rdr(16'h0100, rd, rs);
        `CHK("unmapped rresp", pic_pkg::PIC_RESP_SLVERR, rs)
        `CHK("unmapped rdata", 32'h0000_0000, rd)
        tally_and_finish();
    end
endmodule
`default_nettype wire
